/* File: core/rtc_cfg.svh */
// Constants of the two-wire register access slave: device address, byte framing.
// Assumes inclusion by bare name from the package and the design file.
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

`define RTC_DEV_ADDR     7'h68
`define RTC_BYTE_BITS    4'h8
`define RTC_LAST_TX_BIT  4'h7
`define RTC_PTR_RESET    8'h00

`endif

/* File: core/rtc_i2c_slave.sv */
// Two-wire register access slave with its synchroniser and clock-crossing FIFO.
// Assumes a register file on clk_sys_i that takes one write per accepted word and
// returns read data one cycle after rd_en_o; SCL/SDA arrive asynchronously.
`include "rtc_cfg.svh"

// ****************************************************************
// Three-stage synchroniser with agreement filter
// ****************************************************************
module rtc_sync3 #(
  parameter int             W  = 1,
  parameter logic [W-1:0]   RV = '0
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= RV;
      s2_reg <= RV;
      s3_reg <= RV;
      q_o    <= RV;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      // A change is taken only once the last two stages agree.
      if (s2_reg == s3_reg) begin
        q_o <= s3_reg;
      end
    end
  end
endmodule : rtc_sync3

// ****************************************************************
// Asynchronous FIFO with gray-coded pointers
// ****************************************************************
module rtc_afifo #(
  parameter int W     = 16,
  parameter int DEPTH = 8
) (
  input  wire logic         wclk_i,
  input  wire logic         wrst_i,
  input  wire logic         w_valid_i,
  output logic              w_ready_o,
  input  wire logic [W-1:0] w_data_i,
  input  wire logic         rclk_i,
  input  wire logic         rrst_i,
  output logic              r_valid_o,
  input  wire logic         r_ready_i,
  output logic      [W-1:0] r_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wbin_reg;
  logic [AW:0]  wgray_reg;
  logic [AW:0]  rbin_reg;
  logic [AW:0]  rgray_reg;
  logic [AW:0]  wgray_rs;
  logic [AW:0]  rgray_ws;
  logic [AW:0]  wbin_next;
  logic [AW:0]  rbin_next;

  rtc_sync3 #(.W(AW + 1)) u_rsync (
    .clk_i (rclk_i),
    .rst_i (rrst_i),
    .d_i   (wgray_reg),
    .q_o   (wgray_rs)
  );
  rtc_sync3 #(.W(AW + 1)) u_wsync (
    .clk_i (wclk_i),
    .rst_i (wrst_i),
    .d_i   (rgray_reg),
    .q_o   (rgray_ws)
  );

  assign w_ready_o = (wgray_reg != {~rgray_ws[AW:AW-1], rgray_ws[AW-2:0]});
  assign r_valid_o = (rgray_reg != wgray_rs);
  assign r_data_o  = mem[rbin_reg[AW-1:0]];
  assign wbin_next = wbin_reg + (AW + 1)'(1);
  assign rbin_next = rbin_reg + (AW + 1)'(1);

  always_ff @(posedge wclk_i) begin
    if (wrst_i) begin
      wbin_reg  <= '0;
      wgray_reg <= '0;
    end else if (w_valid_i && w_ready_o) begin
      mem[wbin_reg[AW-1:0]] <= w_data_i;
      wbin_reg  <= wbin_next;
      wgray_reg <= wbin_next ^ (wbin_next >> 1);
    end
  end

  always_ff @(posedge rclk_i) begin
    if (rrst_i) begin
      rbin_reg  <= '0;
      rgray_reg <= '0;
    end else if (r_valid_o && r_ready_i) begin
      rbin_reg  <= rbin_next;
      rgray_reg <= rbin_next ^ (rbin_next >> 1);
    end
  end
endmodule : rtc_afifo

// ****************************************************************
// Slave top level
// ****************************************************************
module rtc_i2c_slave #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic            clk_sys_i,
  input  wire logic            rst_i,
  input  wire logic            clk_link_i,
  input  wire logic            scl_i,
  input  wire logic            sda_i,
  output logic                 sda_o,
  output logic                 sda_oe_o,
  output logic                 wr_valid_o,
  input  wire logic            wr_ready_i,
  output rtc_pkg::rtc_wr_s     wr_o,
  output logic                 rd_en_o,
  output logic      [7:0]      rd_addr_o,
  input  wire logic [7:0]      rd_data_i
);
  logic                 rst_l_q1;
  logic                 rst_l;
  logic [1:0]           pins_s;
  logic                 scl_prev;
  logic                 sda_prev;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_c;
  logic                 stop_c;
  rtc_pkg::rtc_st_e     st_reg;
  rtc_pkg::rtc_kind_e   kind_reg;
  logic [3:0]           cnt_reg;
  logic [7:0]           sh_reg;
  logic [7:0]           tx_reg;
  logic [7:0]           ptr_reg;
  logic                 rw_reg;
  logic                 mack_reg;
  logic                 push_reg;
  rtc_pkg::rtc_wr_s     push_data_reg;
  logic                 f_wready;
  logic                 rreq_tgl_reg;
  logic [7:0]           raddr_reg;
  logic                 rack_s;
  logic                 rack_prev;
  logic [7:0]           rbuf_reg;
  logic                 f_rvalid;
  logic                 f_rready;
  rtc_pkg::rtc_wr_s     f_rdata;
  logic                 rreq_s;
  logic                 rreq_prev;
  logic                 pend_reg;
  logic                 rd_dly_reg;
  logic                 rack_tgl_reg;
  logic [7:0]           rdat_reg;

  // ****************************************************************
  // Link clock domain: reset, pin conditioning, edge detection
  // ****************************************************************
  always_ff @(posedge clk_link_i) begin
    rst_l_q1 <= rst_i;
    rst_l    <= rst_l_q1;
  end

  rtc_sync3 #(.W(2), .RV(2'h3)) u_pins (
    .clk_i (clk_link_i),
    .rst_i (rst_l),
    .d_i   ({scl_i, sda_i}),
    .q_o   (pins_s)
  );

  always_ff @(posedge clk_link_i) begin
    if (rst_l) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= pins_s[1];
      sda_prev <= pins_s[0];
    end
  end

  assign scl_rise = pins_s[1] & ~scl_prev;
  assign scl_fall = ~pins_s[1] & scl_prev;
  // SDA may only move while SCL is high to signal START or STOP.
  assign start_c  = pins_s[1] & scl_prev & sda_prev & ~pins_s[0];
  assign stop_c   = pins_s[1] & scl_prev & ~sda_prev & pins_s[0];

  // ****************************************************************
  // Link clock domain: bit and byte sequencing
  // ****************************************************************
  always_ff @(posedge clk_link_i) begin
    if (rst_l) begin
      st_reg       <= rtc_pkg::ST_IDLE;
      kind_reg     <= rtc_pkg::K_ADDR;
      cnt_reg      <= 4'h0;
      sh_reg       <= 8'h00;
      tx_reg       <= 8'h00;
      ptr_reg      <= `RTC_PTR_RESET;
      rw_reg       <= 1'b0;
      mack_reg     <= 1'b1;
      sda_oe_o     <= 1'b0;
      push_reg     <= 1'b0;
      push_data_reg <= '0;
      rreq_tgl_reg <= 1'b0;
      raddr_reg    <= 8'h00;
    end else begin
      push_reg <= 1'b0;
      if (start_c) begin
        st_reg   <= rtc_pkg::ST_RX;
        kind_reg <= rtc_pkg::K_ADDR;
        cnt_reg  <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        st_reg   <= rtc_pkg::ST_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        unique case (st_reg)
          rtc_pkg::ST_IDLE: begin
          end
          rtc_pkg::ST_RX: begin
            if (scl_rise) begin
              sh_reg  <= {sh_reg[6:0], pins_s[0]};
              cnt_reg <= cnt_reg + 4'h1;
            end
            if (scl_fall && cnt_reg == `RTC_BYTE_BITS) begin
              cnt_reg <= 4'h0;
              unique case (kind_reg)
                rtc_pkg::K_ADDR: begin
                  if (sh_reg[7:1] == `RTC_DEV_ADDR) begin
                    rw_reg   <= sh_reg[0];
                    sda_oe_o <= 1'b1;
                    st_reg   <= rtc_pkg::ST_ACK;
                    kind_reg <= rtc_pkg::K_PTR;
                    if (sh_reg[0]) begin
                      // Fetch the byte the retained pointer selects.
                      rreq_tgl_reg <= ~rreq_tgl_reg;
                      raddr_reg    <= ptr_reg;
                    end
                  end else begin
                    st_reg <= rtc_pkg::ST_IDLE;
                  end
                end
                rtc_pkg::K_PTR: begin
                  ptr_reg  <= sh_reg;
                  sda_oe_o <= 1'b1;
                  st_reg   <= rtc_pkg::ST_ACK;
                  kind_reg <= rtc_pkg::K_DATA;
                end
                default: begin
                  // A full FIFO cannot take the byte, so it is refused.
                  if (f_wready) begin
                    push_reg      <= 1'b1;
                    push_data_reg <= '{addr: ptr_reg, data: sh_reg};
                    ptr_reg       <= ptr_reg + 8'h01;
                    sda_oe_o      <= 1'b1;
                    st_reg        <= rtc_pkg::ST_ACK;
                  end else begin
                    st_reg <= rtc_pkg::ST_IDLE;
                  end
                end
              endcase
            end
          end
          rtc_pkg::ST_ACK: begin
            // Held from one falling edge to the next, so low for all of SCL high.
            if (scl_fall) begin
              cnt_reg <= 4'h0;
              if (rw_reg) begin
                st_reg   <= rtc_pkg::ST_TX;
                tx_reg   <= rbuf_reg;
                sda_oe_o <= ~rbuf_reg[7];
              end else begin
                st_reg   <= rtc_pkg::ST_RX;
                sda_oe_o <= 1'b0;
              end
            end
          end
          rtc_pkg::ST_TX: begin
            if (scl_fall) begin
              if (cnt_reg == `RTC_LAST_TX_BIT) begin
                sda_oe_o     <= 1'b0;
                st_reg       <= rtc_pkg::ST_MACK;
                ptr_reg      <= ptr_reg + 8'h01;
                rreq_tgl_reg <= ~rreq_tgl_reg;
                raddr_reg    <= ptr_reg + 8'h01;
              end else begin
                tx_reg   <= {tx_reg[6:0], 1'b0};
                sda_oe_o <= ~tx_reg[6];
                cnt_reg  <= cnt_reg + 4'h1;
              end
            end
          end
          rtc_pkg::ST_MACK: begin
            if (scl_rise) begin
              mack_reg <= pins_s[0];
            end
            if (scl_fall) begin
              cnt_reg <= 4'h0;
              if (!mack_reg) begin
                st_reg   <= rtc_pkg::ST_TX;
                tx_reg   <= rbuf_reg;
                sda_oe_o <= ~rbuf_reg[7];
              end else begin
                st_reg <= rtc_pkg::ST_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Link clock domain: read data return; sda_o register held low on clk_sys_i
  // ****************************************************************
  rtc_sync3 #(.W(1)) u_rack (
    .clk_i (clk_link_i),
    .rst_i (rst_l),
    .d_i   (rack_tgl_reg),
    .q_o   (rack_s)
  );

  // Read data is held stable on the system side until the next request.
  always_ff @(posedge clk_link_i) begin
    if (rst_l) begin
      rack_prev <= 1'b0;
      rbuf_reg  <= 8'h00;
    end else begin
      rack_prev <= rack_s;
      if (rack_s != rack_prev) begin
        rbuf_reg <= rdat_reg;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  // ****************************************************************
  // Crossing FIFO for write words
  // ****************************************************************
  rtc_afifo #(.W($bits(rtc_pkg::rtc_wr_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .wclk_i    (clk_link_i),
    .wrst_i    (rst_l),
    .w_valid_i (push_reg),
    .w_ready_o (f_wready),
    .w_data_i  (push_data_reg),
    .rclk_i    (clk_sys_i),
    .rrst_i    (rst_i),
    .r_valid_o (f_rvalid),
    .r_ready_i (f_rready),
    .r_data_o  (f_rdata)
  );

  // ****************************************************************
  // System clock domain: register file writes and reads
  // ****************************************************************
  assign f_rready = ~wr_valid_o | wr_ready_i;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_valid_o <= 1'b0;
      wr_o       <= '0;
    end else if (f_rvalid && f_rready) begin
      wr_valid_o <= 1'b1;
      wr_o       <= f_rdata;
    end else if (wr_ready_i) begin
      wr_valid_o <= 1'b0;
    end
  end

  rtc_sync3 #(.W(1)) u_rreq (
    .clk_i (clk_sys_i),
    .rst_i (rst_i),
    .d_i   (rreq_tgl_reg),
    .q_o   (rreq_s)
  );

  // A read waits for earlier writes to drain, so a register just written reads back its new value.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rreq_prev    <= 1'b0;
      pend_reg     <= 1'b0;
      rd_en_o      <= 1'b0;
      rd_addr_o    <= 8'h00;
      rd_dly_reg   <= 1'b0;
      rack_tgl_reg <= 1'b0;
      rdat_reg     <= 8'h00;
    end else begin
      rreq_prev  <= rreq_s;
      rd_en_o    <= 1'b0;
      rd_dly_reg <= rd_en_o;
      if (pend_reg && !f_rvalid && !wr_valid_o) begin
        rd_en_o   <= 1'b1;
        rd_addr_o <= raddr_reg;
      end
      pend_reg <= (pend_reg & ~(!f_rvalid && !wr_valid_o)) | (rreq_s != rreq_prev);
      if (rd_dly_reg) begin
        rdat_reg     <= rd_data_i;
        rack_tgl_reg <= ~rack_tgl_reg;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_start;
    @(posedge clk_link_i) disable iff (rst_l)
    start_c |=> (st_reg == rtc_pkg::ST_RX) && (kind_reg == rtc_pkg::K_ADDR) && !sda_oe_o;
  endproperty
  a_start: assert property (p_start) else $error("START not taken");

  property p_stop;
    @(posedge clk_link_i) disable iff (rst_l)
    (stop_c && !start_c) |=> (st_reg == rtc_pkg::ST_IDLE) && !sda_oe_o;
  endproperty
  a_stop: assert property (p_stop) else $error("STOP not taken");

  property p_addr_ack;
    @(posedge clk_link_i) disable iff (rst_l)
    (st_reg == rtc_pkg::ST_RX && kind_reg == rtc_pkg::K_ADDR && scl_fall && !start_c
     && !stop_c && cnt_reg == 4'h8 && sh_reg[7:1] == 7'h68)
    |=> (st_reg == rtc_pkg::ST_ACK) && sda_oe_o && (rw_reg == $past(sh_reg[0]));
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");

  property p_addr_nack;
    @(posedge clk_link_i) disable iff (rst_l)
    (st_reg == rtc_pkg::ST_RX && kind_reg == rtc_pkg::K_ADDR && scl_fall && !start_c
     && !stop_c && cnt_reg == 4'h8 && sh_reg[7:1] != 7'h68)
    |=> (st_reg == rtc_pkg::ST_IDLE) && !sda_oe_o;
  endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("foreign address answered");

  property p_ptr_load;
    @(posedge clk_link_i) disable iff (rst_l)
    (st_reg == rtc_pkg::ST_RX && kind_reg == rtc_pkg::K_PTR && scl_fall && !start_c
     && !stop_c && cnt_reg == 4'h8) |=> (ptr_reg == $past(sh_reg)) && sda_oe_o;
  endproperty
  a_ptr_load: assert property (p_ptr_load) else $error("pointer not loaded");

  property p_tx_inc;
    @(posedge clk_link_i) disable iff (rst_l)
    (st_reg == rtc_pkg::ST_TX && scl_fall && !start_c && !stop_c && cnt_reg == 4'h7)
    |=> (ptr_reg == $past(ptr_reg) + 8'h01) && !sda_oe_o;
  endproperty
  a_tx_inc: assert property (p_tx_inc) else $error("pointer not advanced");

  property p_msb_first;
    @(posedge clk_link_i) disable iff (rst_l)
    (st_reg == rtc_pkg::ST_ACK && rw_reg && scl_fall && !start_c && !stop_c)
    |=> (st_reg == rtc_pkg::ST_TX) && (sda_oe_o == !$past(rbuf_reg[7]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("read byte not MSB first");

  property p_release;
    @(posedge clk_link_i) disable iff (rst_l)
    (st_reg == rtc_pkg::ST_MACK && mack_reg && scl_fall && !start_c && !stop_c)
    |=> !sda_oe_o [*2];
  endproperty
  a_release: assert property (p_release) else $error("SDA held after NACK");

  property p_ack_hold;
    @(posedge clk_link_i) disable iff (rst_l)
    (st_reg == rtc_pkg::ST_ACK && pins_s[1] && !stop_c) |-> sda_oe_o;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ACK not held low");

endmodule : rtc_i2c_slave

/* File: core/rtc_pkg.sv */
// Types shared by the two-wire register access slave.
// Assumes rtc_cfg.svh sits on the include path.
`include "rtc_cfg.svh"

package rtc_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } rtc_wr_s;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK} rtc_st_e;

  typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} rtc_kind_e;

endpackage : rtc_pkg

/* File: verification/rtc_bus_master.sv */
// Bus master model: drives SCL, pulls SDA low, and frames bytes for the slave.
// Assumes the bench resolves SDA as an open-drain line with a pull-up.
module rtc_bus_master (
  output logic      scl_o,
  output logic      pull_o,
  input  wire logic sda_i
);
  timeunit 1ns;
  timeprecision 100ps;

  // Half an SCL period, long against the slave's input filter latency.
  localparam int HALF = 120;

  initial begin
    scl_o  = 1'b1;
    pull_o = 1'b0;
  end

  // Serves as a first or a repeated start, because SCL is low in between.
  task automatic start_cond();
    #20 pull_o = 1'b0;
    #HALF scl_o = 1'b1;
    #HALF pull_o = 1'b1;
    #HALF scl_o = 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    #20 pull_o = 1'b1;
    #HALF scl_o = 1'b1;
    #HALF pull_o = 1'b0;
    #HALF;
  endtask : stop_cond

  // SDA is sampled early and late in the high phase; a change returns x.
  task automatic clk_bit(input logic b, output logic s);
    logic s0;
    #20 pull_o = ~b;
    #HALF scl_o = 1'b1;
    #20 s0 = sda_i;
    #(HALF - 40) s = (sda_i === s0) ? s0 : 1'bx;
    #20 scl_o = 1'b0;
  endtask : clk_bit

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte

  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, d[i]);
    end
    clk_bit(~ack, s);
  endtask : recv_byte
endmodule : rtc_bus_master

/* File: verification/rtc_i2c_slave_test.sv */
// Self-checking bench of the two-wire slave: bus master model on the link and
// a register file model on the system side. Assumes the core files come first.
module rtc_i2c_slave_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic             clk_sys_i;
  logic             clk_link_i;
  logic             rst_i;
  logic             scl;
  logic             pull;
  logic             sda_oe_o;
  logic             sda_o;
  logic             rd_seen;
  logic             wr_valid_o;
  logic             wr_ready_i;
  rtc_pkg::rtc_wr_s wr_o;
  logic             rd_en_o;
  logic [7:0]       rd_addr_o;
  logic [7:0]       rd_data_i;
  wire              sda;
  logic [7:0]       mem [256];
  rtc_pkg::rtc_wr_s exp_wr [$];
  logic [7:0]       exp_rd [$];
  logic [7:0]       ptr;
  logic             stall;
  int               bad_count;
  int               samples_checked;

  // Open drain with a pull-up: a released line reads high, and the pad drives sda_o.
  assign sda = ~(pull | (sda_oe_o & ~sda_o));

  rtc_i2c_slave #(.FIFO_DEPTH(8)) uut (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .clk_link_i (clk_link_i),
    .scl_i      (scl),
    .sda_i      (sda),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe_o),
    .wr_valid_o (wr_valid_o),
    .wr_ready_i (wr_ready_i),
    .wr_o       (wr_o),
    .rd_en_o    (rd_en_o),
    .rd_addr_o  (rd_addr_o),
    .rd_data_i  (rd_data_i)
  );

  rtc_bus_master bm (.scl_o(scl), .pull_o(pull), .sda_i(sda));

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    clk_link_i = 1'b0;
    #1.3;
    forever #3 clk_link_i = ~clk_link_i;
  end

  // ****************************************************************
  // Register file model and result watcher
  // ****************************************************************
  // Read data is valid only in the cycle after the strobe; noise otherwise.
  always @(negedge clk_sys_i) begin
    wr_ready_i <= stall ? 1'b0 : 1'($urandom % 2);
    rd_data_i  <= rd_seen ? mem[rd_addr_o] : 8'($urandom);
    rd_seen    <= (rd_en_o === 1'b1);
  end

  always @(posedge clk_sys_i) begin
    if (rst_i === 1'b0 && wr_valid_o === 1'b1 && wr_ready_i === 1'b1) begin
      mem[wr_o.addr] = wr_o.data;
      chk_wr(wr_o);
    end
  end

  task automatic fail(input string msg);
    bad_count++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    samples_checked++;
    if (got !== exp) fail(msg);
  endtask : chk_bit

  task automatic chk_wr(input rtc_pkg::rtc_wr_s got);
    samples_checked++;
    if (exp_wr.size() == 0) fail("unexpected register write");
    else if (got !== exp_wr.pop_front()) fail("register write mismatch");
  endtask : chk_wr

  task automatic chk_rd(input logic [7:0] got);
    samples_checked++;
    if (got !== exp_rd.pop_front()) fail("read byte mismatch");
  endtask : chk_rd

  task automatic drain();
    int n;
    n = 0;
    while (exp_wr.size() != 0 && n < 2000) begin
      @(posedge clk_sys_i);
      n++;
    end
    chk_bit(exp_wr.size() == 0, 1'b1, "writes not delivered");
  endtask : drain

  // ****************************************************************
  // Transfers
  // ****************************************************************
  // With full set, the register file is stalled and bytes go on until one is refused.
  task automatic wr_seq(input logic [7:0] p, input int n, input logic full);
    logic       a;
    logic [7:0] d;
    int         k;
    bm.start_cond();
    bm.send_byte(8'hd0, a);
    chk_bit(a, 1'b1, "write address not acknowledged");
    bm.send_byte(p, a);
    chk_bit(a, 1'b1, "pointer byte not acknowledged");
    ptr = p;
    for (k = 0; k < n; k++) begin
      d = 8'($urandom);
      exp_wr.push_back({ptr, d});
      bm.send_byte(d, a);
      if (full && a !== 1'b1) begin
        void'(exp_wr.pop_back());
        break;
      end
      chk_bit(a, 1'b1, "data byte not acknowledged");
      ptr++;
    end
    // Eight words wait in the buffer and one more is held at the write port.
    if (full) chk_bit(k == 9, 1'b1, "buffer refusal point wrong");
    bm.stop_cond();
    stall = 1'b0;
    drain();
    $display("write at %h with %0d bytes done", p, k);
  endtask : wr_seq

  task automatic rd_seq(input logic setp, input logic [7:0] p, input int n);
    logic       a;
    logic [7:0] d;
    bm.start_cond();
    if (setp) begin
      bm.send_byte(8'hd0, a);
      bm.send_byte(p, a);
      chk_bit(a, 1'b1, "pointer byte not acknowledged");
      ptr = p;
      bm.start_cond();
    end
    bm.send_byte(8'hd1, a);
    chk_bit(a, 1'b1, "read address not acknowledged");
    for (int i = 0; i < n; i++) begin
      exp_rd.push_back(mem[ptr]);
      bm.recv_byte(i < n - 1, d);
      chk_rd(d);
      ptr++;
    end
    #60;
    chk_bit(sda, 1'b1, "data line held after final byte");
    bm.stop_cond();
    $display("read of %0d bytes done", n);
  endtask : rd_seq

  task automatic bad_addr();
    logic a;
    for (int i = 0; i < 4; i++) begin
      bm.start_cond();
      bm.send_byte({7'h68 ^ 7'(1 << ($urandom % 7)), i[0]}, a);
      chk_bit(a, 1'b0, "foreign address acknowledged");
      bm.send_byte(8'($urandom), a);
      chk_bit(a, 1'b0, "byte after foreign address acknowledged");
      bm.stop_cond();
    end
    $display("foreign address test done");
  endtask : bad_addr

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  initial begin
    rst_i           = 1'b1;
    wr_ready_i      = 1'b0;
    rd_data_i       = 8'h00;
    rd_seen         = 1'b0;
    stall           = 1'b0;
    ptr             = 8'h00;
    bad_count       = 0;
    samples_checked = 0;
    void'($urandom(32'h6197));
    for (int i = 0; i < 256; i++) mem[i] = 8'($urandom);
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (20) @(negedge clk_sys_i);
    rd_seq(1'b0, 8'h00, 2);
    wr_seq(8'hfe, 4, 1'b0);
    wr_seq(8'($urandom), 0, 1'b0);
    rd_seq(1'b0, 8'h00, 3);
    rd_seq(1'b1, 8'hfe, 4);
    bad_addr();
    stall = 1'b1;
    wr_seq(8'h40, 12, 1'b1);
    rd_seq(1'b1, 8'h40, 3);
    print_verdict();
  end

  initial begin
    #300000;
    fail("watchdog expired");
    print_verdict();
  end
endmodule : rtc_i2c_slave_test
